/* File: core/io_space_defs.vh */
// Purpose: Constants for the core I/O register block.
// Assumes: Byte-wide data bus, 16-bit data-space address, 6-bit I/O address.
// Notes: Included by both design files.
`ifndef IO_SPACE_DEFS_VH
`define IO_SPACE_DEFS_VH
`define IO_OFFSET 16'h0020
`define IO_ADDR_MAX 16'h003F
`define EXT_IO_BASE 16'h0060
`define FLAGS_ADDR 16'h005F
`define NVM_LOW_ADDR 16'h0041
`define NVM_HIGH_STEP 16'h0001
`define SCRATCH_ADDR 16'h004A
`define FLAGS_RESET 8'h00
`define SCRATCH_RESET 8'h00
`define NVM_HIGH_BITS 3
`define NVM_ADDR_BITS 11
`define BIT_I 7
`define BIT_T 6
`define BIT_H 5
`define BIT_S 4
`define BIT_V 3
`define BIT_N 2
`define BIT_Z 1
`define BIT_C 0
`endif

/* File: core/io_addr_decode.v */
// Purpose: Maps a data-space or short I/O access to a data-space address.
// Assumes: I/O addresses are six bits wide.
// Notes: Purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "io_space_defs.vh"
module io_addr_decode (
	input wire i_is_io,
	input wire [5:0] i_io_addr,
	input wire [15:0] i_data_addr,
	output reg [15:0] o_data_addr,
	output reg o_short_ok
);
	always @* begin
		if (i_is_io) begin
			o_data_addr = {10'h000, i_io_addr} + `IO_OFFSET;
		end else begin
			o_data_addr = i_data_addr;
		end
		// Short I/O instructions can never reach extended space.
		o_short_ok = !i_is_io || (o_data_addr < `EXT_IO_BASE);
	end
endmodule // io_addr_decode
`default_nettype wire

/* File: core/io_space_core_registers.v */
// Purpose: Flag, nonvolatile address and scratch registers of the core I/O space.
// Assumes: The core presents one access per cycle with a decoded address.
// Notes: Read data is registered; it appears the cycle after the read strobe.
// How it works
// - I/O address is data address minus 0x20.
// - Extended space only via data-space access.
// - Interrupts gated by global enable bit.
// - Interrupt taken clears enable; return sets it.
// - Unmask sets enable, mask clears it.
// - Bit store and load use copy bit.
// - Sign equals negative xor overflow.
// - Negative flag marks negative result.
// - Zero flag marks zero result.
// - Half carry records low nibble carry.
// - Flags at 0x5F/0x3F, all R/W, reset zero.
// - Address pair low at base, high base+1.
// - Address selects one of 2048 bytes.
// - Address register not reset.
// - Address pair at 0x41, I/O 0x21.
// - Scratch at 0x4A/0x2A, R/W, reset zero.
`timescale 1ns/100ps
`default_nettype none
`include "io_space_defs.vh"
module io_space_core_registers (
	input wire i_sys_clk,
	input wire i_rst,
	input wire i_wr,
	input wire i_rd,
	input wire i_is_io,
	input wire [5:0] i_io_addr,
	input wire [15:0] i_data_addr,
	input wire [7:0] i_wdata,
	input wire i_irq_pending,
	input wire i_irq_taken,
	input wire i_irq_return_op,
	input wire i_irq_unmask_op,
	input wire i_irq_mask_op,
	input wire i_bit_to_flag_op,
	input wire i_bit_value,
	input wire i_alu_upd,
	input wire [7:0] i_alu_result,
	input wire i_alu_upd_h,
	input wire i_alu_h,
	input wire i_alu_v,
	input wire i_alu_c,
	output reg [7:0] o_rdata,
	output reg o_hit,
	output reg o_irq_req,
	output reg o_copy_bit,
	output reg [7:0] o_flags,
	output reg [10:0] o_nvm_addr
);
	reg [7:0] cpu_flags_reg;
	reg [7:0] cpu_flags_next;
	reg [7:0] scratch_byte_one_reg;
	reg [7:0] nvm_addr_low_reg;
	reg [`NVM_HIGH_BITS-1:0] nvm_addr_high_reg;
	wire [15:0] eff_addr;
	wire short_ok;
	reg sel_flags;
	reg sel_low;
	reg sel_high;
	reg sel_scr;
	reg neg;
	reg [7:0] rd_next;

	io_addr_decode u_dec (
		.i_is_io(i_is_io),
		.i_io_addr(i_io_addr),
		.i_data_addr(i_data_addr),
		.o_data_addr(eff_addr),
		.o_short_ok(short_ok)
	);

	always @* begin
		sel_flags = short_ok && (eff_addr == `FLAGS_ADDR);
		sel_low = short_ok && (eff_addr == `NVM_LOW_ADDR);
		sel_high = short_ok && (eff_addr == (`NVM_LOW_ADDR + `NVM_HIGH_STEP));
		sel_scr = short_ok && (eff_addr == `SCRATCH_ADDR);
	end

	always @* begin
		cpu_flags_next = cpu_flags_reg;
		neg = cpu_flags_reg[`BIT_N];
		// A bus write to the flags wins over any instruction effect in the same cycle.
		// The core normally issues one of them per cycle, so a plain priority order suffices.
		if (i_wr && sel_flags) begin
			cpu_flags_next = i_wdata;
		end else if (i_irq_taken) begin
			cpu_flags_next[`BIT_I] = 1'b0;
		end else if (i_irq_return_op || i_irq_unmask_op) begin
			cpu_flags_next[`BIT_I] = 1'b1;
		end else if (i_irq_mask_op) begin
			cpu_flags_next[`BIT_I] = 1'b0;
		end else if (i_bit_to_flag_op) begin
			cpu_flags_next[`BIT_T] = i_bit_value;
		end else if (i_alu_upd) begin
			neg = i_alu_result[7];
			cpu_flags_next[`BIT_N] = neg;
			cpu_flags_next[`BIT_Z] = (i_alu_result == 8'h00);
			cpu_flags_next[`BIT_V] = i_alu_v;
			cpu_flags_next[`BIT_S] = neg ^ i_alu_v;
			cpu_flags_next[`BIT_C] = i_alu_c;
			if (i_alu_upd_h) begin
				cpu_flags_next[`BIT_H] = i_alu_h;
			end
		end
	end

	always @* begin
		rd_next = 8'h00;
		if (sel_flags) begin
			rd_next = cpu_flags_reg;
		end else if (sel_low) begin
			rd_next = nvm_addr_low_reg;
		end else if (sel_high) begin
			rd_next = {5'h00, nvm_addr_high_reg};
		end else if (sel_scr) begin
			rd_next = scratch_byte_one_reg;
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			cpu_flags_reg <= `FLAGS_RESET;
			scratch_byte_one_reg <= `SCRATCH_RESET;
			o_rdata <= 8'h00;
			o_hit <= 1'b0;
			o_irq_req <= 1'b0;
			o_copy_bit <= 1'b0;
			o_flags <= `FLAGS_RESET;
		end else begin
			cpu_flags_reg <= cpu_flags_next;
			if (i_wr && sel_scr) begin
				scratch_byte_one_reg <= i_wdata;
			end
			if (i_rd) begin
				o_rdata <= rd_next;
			end
			o_hit <= (i_rd || i_wr) && (sel_flags || sel_low || sel_high || sel_scr);
			// Gating uses the next flag value so a mask takes effect at once.
			o_irq_req <= i_irq_pending && cpu_flags_next[`BIT_I] && !i_irq_taken;
			o_copy_bit <= cpu_flags_next[`BIT_T];
			o_flags <= cpu_flags_next;
		end
	end

	// The address pair is deliberately left out of reset; software must load it first.
	always @(posedge i_sys_clk) begin
		if (i_wr && sel_low) begin
			nvm_addr_low_reg <= i_wdata;
		end
		if (i_wr && sel_high) begin
			nvm_addr_high_reg <= i_wdata[`NVM_HIGH_BITS-1:0];
		end
		o_nvm_addr <= {nvm_addr_high_reg, nvm_addr_low_reg};
	end
endmodule // io_space_core_registers
`default_nettype wire

/* File: dv/io_props.sv */
// Purpose: Timing checks on flag and read paths.
// Assumes: Flag copy updates on the same edge as the flag register.
// Notes: Bound from tb_top.
`timescale 1ns/100ps
`default_nettype none
module io_props(
	input wire logic i_sys_clk,i_rst,i_rd,i_wr,i_irq_taken,i_irq_unmask_op,
	input wire logic i_bit_to_flag_op,i_bit_value,i_alu_upd,o_irq_req,
	input wire logic i_alu_upd_h,i_alu_h,
	input wire logic [7:0] i_alu_result,o_rdata,o_flags
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	a_sign_xor: assert property (i_alu_upd&&!i_wr |-> ##2 o_flags[4]==^o_flags[3:2]) else $error("sign");
	a_neg_zero: assert property (i_alu_upd&&!i_wr |-> ##2 o_flags[2:1]==
		{$past(i_alu_result,2)>=8'h80,$past(i_alu_result,2)==8'h00}) else $error("nz");
	a_taken_clr: assert property (i_irq_taken&&!i_wr |-> ##2 !o_flags[7]) else $error("taken");
	a_taken_noreq: assert property (i_irq_taken |=> !o_irq_req) else $error("req");
	a_unmask_set: assert property (i_irq_unmask_op&&!i_wr&&!i_irq_taken |-> ##2 o_flags[7]) else $error("set");
	a_copy_store: assert property (i_bit_to_flag_op&&!i_wr |-> ##2 o_flags[6]==$past(i_bit_value,2)) else $error("t");
	a_req_gated: assert property (o_irq_req |-> o_flags[7]) else $error("gate");
	a_half_carry: assert property (i_alu_upd&&i_alu_upd_h&&!i_wr |-> ##2 o_flags[5]==$past(i_alu_h,2)) else $error("h");
	a_rdata_hold: assert property (!i_rd |=> $stable(o_rdata)) else $error("hold");
endmodule // io_props
`default_nettype wire

/* File: dv/cpu_bus.sv */
// Purpose: Core-side bus model.
// Assumes: One access in flight.
// Notes: Released lines carry inverted values so stale data is never read.
`timescale 1ns/100ps
`default_nettype none
module cpu_bus(
	input wire logic i_clk,
	output logic o_w,o_r,o_i,
	output logic [5:0] o_ia,
	output logic [15:0] o_da,
	output logic [7:0] o_wd
);
	initial {o_w,o_r,o_i,o_ia,o_da,o_wd}=33'h0;
	task acc(input logic w,i,input logic [15:0] a,input logic [7:0] d);
		@(posedge i_clk) {o_w,o_r,o_i,o_ia,o_da,o_wd}<={w,!w,i,a[5:0]-6'h20,a,d};
		@(posedge i_clk) {o_w,o_r,o_ia,o_da,o_wd}<={2'h0,~a[5:0],~a,~d};
	endtask
endmodule // cpu_bus
`default_nettype wire

/* File: dv/tb_top.sv */
// Purpose: Register and flag tests.
// Assumes: Read data settles the cycle after the strobe.
// Notes: Op pulses come from one vector.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic i_sys_clk=1'h0,i_rst=1'h1,i_irq_pending=1'h1;
	logic [18:0] ov=19'h0;
	integer mismatches=0,n_compared=0,cyc=0;
	wire i_irq_taken=ov[16],i_irq_return_op=ov[15],i_irq_unmask_op=ov[14],i_irq_mask_op=ov[13];
	wire i_bit_to_flag_op=ov[12],i_bit_value=ov[11],i_alu_upd=ov[10],i_alu_v=ov[9],i_alu_c=ov[8];
	wire [7:0] i_alu_result=ov[7:0];
	wire i_alu_upd_h=ov[18],i_alu_h=ov[17];
	wire i_wr,i_rd,i_is_io,o_hit,o_irq_req,o_copy_bit;
	wire [5:0] i_io_addr;
	wire [15:0] i_data_addr;
	wire [7:0] i_wdata,o_rdata,o_flags;
	wire [10:0] o_nvm_addr;
	always #2.5 i_sys_clk=~i_sys_clk;
	cpu_bus cpu(.i_clk(i_sys_clk),.o_w(i_wr),.o_r(i_rd),.o_i(i_is_io),.o_ia(i_io_addr),
		.o_da(i_data_addr),.o_wd(i_wdata));
	io_space_core_registers uut(.*);
	task chk(input logic [15:0] s,e);
		n_compared++;
		if (s!==e) begin
			mismatches++;
			$display("BAD %0t %h %h",$time,s,e);
		end
	endtask
	task rx(input logic i,input logic [15:0] a,input logic [8:0] e);
		cpu.acc(1'h0,i,a,8'h00);
		#1 chk(16'({o_hit,o_rdata}),16'(e));
	endtask
	task op(input logic [18:0] c,input logic [7:0] e);
		@(posedge i_sys_clk) ov<=c;
		@(posedge i_sys_clk) ov<=19'h0;
		@(posedge i_sys_clk) #1 chk(16'({o_copy_bit,o_irq_req,o_flags}),16'({e[6],e[7],e}));
	endtask
	task stop_test;
		$display("compared %0d mismatches %0d",n_compared,mismatches);
		if (mismatches==0&&n_compared>0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge i_sys_clk) if (++cyc==400) begin
		mismatches++;
		stop_test;
	end
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_rst<=1'h0;
		rx(1'h1,16'h005F,9'h100);
		rx(1'h0,16'h004A,9'h100);
		cpu.acc(1'h1,1'h0,16'h004A,8'hA5);
		rx(1'h1,16'h004A,9'h1A5);
		cpu.acc(1'h1,1'h1,16'h0041,8'hFF);
		cpu.acc(1'h1,1'h0,16'h0042,8'hFF);
		rx(1'h1,16'h0042,9'h107);
		rx(1'h0,16'h0041,9'h1FF);
		chk(16'(o_nvm_addr),16'h07FF);
		rx(1'h0,16'h0060,9'h000);
		$display("register test done");
		cpu.acc(1'h1,1'h1,16'h005F,8'hFF);
		op(19'h10000,8'h7F);
		op(19'h04000,8'hFF);
		@(posedge i_sys_clk) i_irq_pending<=1'h0;
		repeat (2) @(posedge i_sys_clk);
		#1 chk(16'(o_irq_req),16'h0000);
		@(posedge i_sys_clk) i_irq_pending<=1'h1;
		op(19'h02000,8'h7F);
		op(19'h08000,8'hFF);
		op(19'h01000,8'hBF);
		op(19'h00680,8'hAC);
		op(19'h00700,8'hBB);
		op(19'h40700,8'h9B);
		op(19'h60700,8'hBB);
		$display("flag test done");
		stop_test;
	end
endmodule // tb_top
bind io_space_core_registers io_props p(.*);
`default_nettype wire
